// file: hw/lmp_dev.sv
// Node end: decodes diagnostic application writing frames
// What this block does
// - Frame id 0x3C, first byte 0x80
// - Byte two: bit7 set, code 0x08 dual
// - Broadcast zero makes every node move
// - Byte four: first max, min velocity
// - Low nibble also second-motion velocity
// - Target bytes five-six, displacement seven-eight
// - Ignore positioning until dual move completes
// - Master avoids target equal actual position
// - Code 0x16: currents, velocities as nibbles
// - Stall bytes six to eight fields
// - Broadcast zero: all nodes store parameters
// - Code 0x09: currents, velocities, secure position
// - Motor byte eight fixed bits, modes
// - Motor parameters act on running motion
// - Code 0x10: fuse index, data, fill
// - Broadcast zero: all nodes program fuse
`timescale 1ns/1ps
module lmp_dev (
	input  logic                mclk_in,
	input  logic                arst_n_in,
	lmp_link_if.dev             link,
	input  logic [6:0]          phys_addr_in,
	input  logic                motion_done_in,
	output logic                move_start_out,
	output logic                move_busy_out,
	output logic [3:0]          move_vmax_out,
	output logic [3:0]          move_vmin_out,
	output logic [15:0]         first_target_position_out,
	output logic [15:0]         second_relative_move_out,
	output lmp_pkg::lmp_param_s param_out,
	output logic                param_load_out,
	output logic                fuse_prog_out,
	output logic [2:0]          fuse_byte_index_out,
	output logic [7:0]          fuse_data_out,
	output logic [7:0]          frames_taken_out,
	output logic [7:0]          frames_dropped_out
);
	import lmp_pkg::*;

	// ----------------------------------------
	// Frame collection
	// ----------------------------------------
	logic                     frm_ok;
	logic [7:0]               frm_id;
	logic [LMP_NBYTES:1][7:0] d;

	lmp_frame_rx #(
		.NBYTES (LMP_NBYTES)
	) lmp_frame_rx_inst (
		.mclk_in      (mclk_in),
		.arst_n_in    (arst_n_in),
		.valid_in     (link.valid),
		.sof_in       (link.sof),
		.byte_in      (link.data),
		.frame_ok_out (frm_ok),
		.id_out       (frm_id),
		.data_out     (d)
	);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	logic       hdr_ok;
	logic       for_me;
	logic [6:0] code;

	always_comb begin
		hdr_ok = frm_ok && (frm_id == LMP_DIAG_ID)
			&& (d[1] == LMP_APP_CMD);
		hdr_ok = hdr_ok && d[2][7];
		code   = d[2][6:0];
		for_me = !d[3][7] || (d[3][6:0] == phys_addr_in);
	end

	// ----------------------------------------
	// Command execution state
	// ----------------------------------------
	logic        busy_reg, busy_next;
	logic        start_reg, start_next;
	logic [3:0]  vmax_reg, vmax_next;
	logic [3:0]  vmin_reg, vmin_next;
	logic [15:0] tgt_reg, tgt_next;
	logic [15:0] rel_reg, rel_next;
	lmp_param_s  par_reg, par_next;
	logic        load_reg, load_next;
	logic        fuse_reg, fuse_next;
	logic [2:0]  fidx_reg, fidx_next;
	logic [7:0]  fdat_reg, fdat_next;
	logic [7:0]  take_reg, take_next;
	logic [7:0]  drop_reg, drop_next;
	logic        acted;

	always_comb begin
		busy_next  = busy_reg;
		start_next = 1'b0;
		vmax_next  = vmax_reg;
		vmin_next  = vmin_reg;
		tgt_next   = tgt_reg;
		rel_next   = rel_reg;
		par_next   = par_reg;
		load_next  = 1'b0;
		fuse_next  = 1'b0;
		fidx_next  = fidx_reg;
		fdat_next  = fdat_reg;
		take_next  = take_reg;
		drop_next  = drop_reg;
		acted      = 1'b0;
		if (motion_done_in) begin
			busy_next = 1'b0;
		end
		if (hdr_ok && for_me) begin
			case (code)
				LMP_CODE_DUAL: begin
					if (!busy_reg) begin
						acted      = 1'b1;
						busy_next  = 1'b1;
						start_next = 1'b1;
						vmax_next = d[4][7:4];
						vmin_next = d[4][3:0];
						tgt_next = {d[5], d[6]};
						rel_next = {d[7], d[8]};
					end
				end
				LMP_CODE_STALL: begin
					acted     = 1'b1;
					load_next = 1'b1;
					par_next.run_current  = d[4][7:4];
					par_next.hold_current = d[4][3:0];
					par_next.vmax         = d[5][7:4];
					par_next.vmin         = d[5][3:0];
					par_next.min_sample_count         = d[6][7:5];
					par_next.shaft_dir                = d[6][4];
					par_next.accel_index              = d[6][3:0];
					par_next.absolute_stall_threshold = d[7][7:4];
					par_next.relative_stall_threshold = d[7][3:0];
					par_next.min_zero_crossings       = d[8][7:5];
					par_next.ramp_profile_select      = d[8][4];
					par_next.step_mode                = d[8][3:2];
					par_next.full_duty_stall_enable   = d[8][1];
					par_next.pwm_jitter_enable        = d[8][0];
				end
				LMP_CODE_MOTOR: begin
					if ((d[8] & LMP_MOTOR_FIX) == LMP_MOTOR_FIX) begin
						acted = 1'b1;
						load_next = 1'b1;
						par_next.run_current     = d[4][7:4];
						par_next.hold_current    = d[4][3:0];
						par_next.vmax            = d[5][7:4];
						par_next.vmin            = d[5][3:0];
						par_next.secure_position = {d[6][7:5], d[7]};
						par_next.shaft_dir       = d[6][4];
						par_next.accel_index     = d[6][3:0];
						par_next.pwm_rate_select     = d[8][6];
						par_next.ramp_profile_select = d[8][4];
						par_next.step_mode           = d[8][3:2];
						par_next.pwm_jitter_enable   = d[8][0];
					end
				end
				LMP_CODE_FUSE: begin
					if (d[4][7:3] == LMP_FUSE_HEAD && d[6] == LMP_FILL
						&& d[7] == LMP_FILL && d[8] == LMP_FILL) begin
						acted = 1'b1;
						fuse_next = 1'b1;
						fidx_next = d[4][2:0];
						fdat_next = d[5];
					end
				end
				default: acted = 1'b0;
			endcase
		end
		// Counters wrap; software compares deltas only
		if (acted) begin
			take_next = 8'(take_reg + 8'h01);
		end else if (frm_ok) begin
			drop_next = 8'(drop_reg + 8'h01);
		end
	end

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			busy_reg  <= 1'b0;
			start_reg <= 1'b0;
			vmax_reg  <= 4'h0;
			vmin_reg  <= 4'h0;
			tgt_reg   <= 16'h0000;
			rel_reg   <= 16'h0000;
			par_reg   <= LMP_PARAM_RST;
			load_reg  <= 1'b0;
			fuse_reg  <= 1'b0;
			fidx_reg  <= 3'h0;
			fdat_reg  <= 8'h00;
			take_reg  <= 8'h00;
			drop_reg  <= 8'h00;
		end else begin
			busy_reg  <= busy_next;
			start_reg <= start_next;
			vmax_reg  <= vmax_next;
			vmin_reg  <= vmin_next;
			tgt_reg   <= tgt_next;
			rel_reg   <= rel_next;
			par_reg   <= par_next;
			load_reg  <= load_next;
			fuse_reg  <= fuse_next;
			fidx_reg  <= fidx_next;
			fdat_reg  <= fdat_next;
			take_reg  <= take_next;
			drop_reg  <= drop_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign move_start_out            = start_reg;
	assign move_busy_out             = busy_reg;
	assign move_vmax_out             = vmax_reg;
	assign move_vmin_out             = vmin_reg;
	assign first_target_position_out = tgt_reg;
	assign second_relative_move_out  = rel_reg;
	assign param_out                 = par_reg;
	assign param_load_out            = load_reg;
	assign fuse_prog_out             = fuse_reg;
	assign fuse_byte_index_out       = fidx_reg;
	assign fuse_data_out             = fdat_reg;
	assign frames_taken_out          = take_reg;
	assign frames_dropped_out        = drop_reg;
endmodule

// file: hw/lmp_frame_rx.sv
// Frame collector with checksum check
`timescale 1ns/1ps
module lmp_frame_rx #(
	parameter int NBYTES = lmp_pkg::LMP_NBYTES
) (
	input  logic                   mclk_in,
	input  logic                   arst_n_in,
	input  logic                   valid_in,
	input  logic                   sof_in,
	input  logic [7:0]             byte_in,
	output logic                   frame_ok_out,
	output logic [7:0]             id_out,
	output logic [NBYTES:1][7:0]   data_out
);
	import lmp_pkg::*;

	typedef enum logic [1:0] {
		LMP_RX_HUNT    = 2'b01,
		LMP_RX_COLLECT = 2'b10
	} lmp_rx_e;

	lmp_rx_e                state_reg, state_next;
	logic [3:0]             cnt_reg, cnt_next;
	logic [7:0]             sum_reg, sum_next;
	logic                   ok_reg, ok_next;
	logic [7:0]             id_reg, id_next;
	logic [NBYTES:1][7:0]   buf_reg, buf_next;

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		sum_next   = sum_reg;
		id_next    = id_reg;
		buf_next   = buf_reg;
		ok_next    = 1'b0;
		// A new start always restarts, so a cut frame never completes
		if (valid_in && sof_in) begin
			state_next = LMP_RX_COLLECT;
			id_next    = byte_in;
			cnt_next   = 4'h1;
			sum_next   = 8'h00;
		end else if (valid_in) begin
			case (state_reg)
				LMP_RX_COLLECT: begin
					if (cnt_reg <= 4'(NBYTES)) begin
						buf_next[cnt_reg] = byte_in;
						sum_next = lmp_csum_add(sum_reg, byte_in);
						cnt_next = 4'(cnt_reg + 4'h1);
					end else begin
						ok_next    = (byte_in == ~sum_reg);
						state_next = LMP_RX_HUNT;
					end
				end
				default: state_next = LMP_RX_HUNT;
			endcase
		end
	end

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_reg <= LMP_RX_HUNT;
			cnt_reg   <= 4'h0;
			sum_reg   <= 8'h00;
			ok_reg    <= 1'b0;
			id_reg    <= 8'h00;
			buf_reg   <= '0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			sum_reg   <= sum_next;
			ok_reg    <= ok_next;
			id_reg    <= id_next;
			buf_reg   <= buf_next;
		end
	end

	assign frame_ok_out = ok_reg;
	assign id_out       = id_reg;
	assign data_out     = buf_reg;
endmodule

// file: hw/lmp_host.sv
// Master end: AHB-Lite registers to diagnostic frames
`timescale 1ns/1ps
module lmp_host (
	input  logic        mclk_in,
	input  logic        arst_n_in,
	lmp_link_if.host    link,
	input  logic        hsel_in,
	input  logic [31:0] haddr_in,
	input  logic [1:0]  htrans_in,
	input  logic        hwrite_in,
	input  logic [2:0]  hsize_in,
	input  logic [31:0] hwdata_in,
	input  logic        hready_in,
	output logic        hreadyout_out,
	output logic [31:0] hrdata_out,
	output logic        hresp_out
);
	import lmp_pkg::*;

	typedef enum logic [1:0] {
		LMP_TX_IDLE = 2'b01,
		LMP_TX_SEND = 2'b10
	} lmp_tx_e;

	lmp_tx_e     st_reg, st_next;
	logic        wr_reg, wr_next;
	logic [7:0]  wa_reg, wa_next;
	logic [6:0]  code_reg, code_next;
	logic [7:0]  dest_reg, dest_next;
	logic [31:0] dlo_reg, dlo_next;
	logic [7:0]  dhi_reg, dhi_next;
	logic [15:0] act_reg, act_next;
	logic        ref_reg, ref_next;
	logic [3:0]  cnt_reg, cnt_next;
	logic [7:0]  sum_reg, sum_next;
	logic        val_reg, val_next;
	logic        sof_reg, sof_next;
	logic [7:0]  dat_reg, dat_next;
	logic [31:0] rd_reg, rd_next;
	logic        ap;
	logic        go;
	logic [7:0]  tx_byte;

	always_comb begin
		st_next   = st_reg;
		code_next = code_reg;
		dest_next = dest_reg;
		dlo_next  = dlo_reg;
		dhi_next  = dhi_reg;
		act_next  = act_reg;
		ref_next  = ref_reg;
		cnt_next  = cnt_reg;
		sum_next  = sum_reg;
		go        = 1'b0;
		// Only whole-word single transfers are expected
		ap      = hsel_in && htrans_in[1] && hready_in;
		wr_next = ap && hwrite_in;
		wa_next = ap ? haddr_in[7:0] : wa_reg;
		if (wr_reg) begin
			case (wa_reg)
				LMP_OFS_CMD: begin
					code_next = hwdata_in[6:0];
					dest_next = hwdata_in[15:8];
					go        = hwdata_in[LMP_GO_BIT];
				end
				LMP_OFS_DLO:    dlo_next = hwdata_in;
				LMP_OFS_DHI:    dhi_next = hwdata_in[7:0];
				LMP_OFS_CURPOS: act_next = hwdata_in[15:0];
				default:        go = 1'b0;
			endcase
		end
		// Go while a frame is out is ignored
		if (go && st_reg == LMP_TX_IDLE) begin
			if (code_next == LMP_CODE_DUAL
				&& (dlo_reg[23:8] == act_reg
				|| {dlo_reg[7:0], dhi_reg} == dlo_reg[23:8])) begin
				ref_next = 1'b1;
			end else begin
				ref_next = 1'b0;
				st_next  = LMP_TX_SEND;
				cnt_next = 4'h0;
			end
		end
		case (cnt_reg)
			4'h0:    tx_byte = LMP_DIAG_ID;
			4'h1:    tx_byte = LMP_APP_CMD;
			4'h2:    tx_byte = {1'b1, code_reg};
			4'h3:    tx_byte = dest_reg;
			4'h4:    tx_byte = dlo_reg[31:24];
			4'h5:    tx_byte = dlo_reg[23:16];
			4'h6:    tx_byte = dlo_reg[15:8];
			4'h7:    tx_byte = dlo_reg[7:0];
			4'h8:    tx_byte = dhi_reg;
			4'h9:    tx_byte = ~sum_reg;
			default: tx_byte = 8'h00;
		endcase
		val_next = 1'b0;
		sof_next = 1'b0;
		dat_next = 8'h00;
		if (st_reg == LMP_TX_SEND) begin
			val_next = 1'b1;
			sof_next = (cnt_reg == 4'h0);
			dat_next = tx_byte;
			cnt_next = 4'(cnt_reg + 4'h1);
			if (cnt_reg == 4'h0) begin
				sum_next = 8'h00;
			end else if (cnt_reg != LMP_CSUM_POS) begin
				sum_next = lmp_csum_add(sum_reg, tx_byte);
			end else begin
				st_next = LMP_TX_IDLE;
			end
		end
		// Read data from next values so a write is seen at once
		rd_next = 32'h0000_0000;
		if (ap && !hwrite_in) begin
			case (haddr_in[7:0])
				LMP_OFS_CMD:    rd_next = {16'h0000, dest_next,
					1'b0, code_next};
				LMP_OFS_DLO:    rd_next = dlo_next;
				LMP_OFS_DHI:    rd_next = {24'h000000, dhi_next};
				LMP_OFS_CURPOS: rd_next = {16'h0000, act_next};
				LMP_OFS_STATUS: begin
					rd_next[LMP_ST_BUSY]    = (st_next == LMP_TX_SEND);
					rd_next[LMP_ST_REFUSED] = ref_next;
				end
				default:        rd_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st_reg   <= LMP_TX_IDLE;
			wr_reg   <= 1'b0;
			wa_reg   <= 8'h00;
			code_reg <= 7'h00;
			dest_reg <= 8'h00;
			dlo_reg  <= 32'h0000_0000;
			dhi_reg  <= 8'h00;
			act_reg  <= 16'h0000;
			ref_reg  <= 1'b0;
			cnt_reg  <= 4'h0;
			sum_reg  <= 8'h00;
			val_reg  <= 1'b0;
			sof_reg  <= 1'b0;
			dat_reg  <= 8'h00;
			rd_reg   <= 32'h0000_0000;
		end else begin
			st_reg   <= st_next;
			wr_reg   <= wr_next;
			wa_reg   <= wa_next;
			code_reg <= code_next;
			dest_reg <= dest_next;
			dlo_reg  <= dlo_next;
			dhi_reg  <= dhi_next;
			act_reg  <= act_next;
			ref_reg  <= ref_next;
			cnt_reg  <= cnt_next;
			sum_reg  <= sum_next;
			val_reg  <= val_next;
			sof_reg  <= sof_next;
			dat_reg  <= dat_next;
			rd_reg   <= rd_next;
		end
	end

	assign link.valid    = val_reg;
	assign link.sof      = sof_reg;
	assign link.data     = dat_reg;
	assign hreadyout_out = 1'b1;
	assign hresp_out     = 1'b0;
	assign hrdata_out    = rd_reg;
endmodule

// file: hw/lmp_link_if.sv
// Byte link between the LIN master end and the node end
`timescale 1ns/1ps
interface lmp_link_if;
	logic       valid;
	logic       sof;
	logic [7:0] data;

	modport host (output valid, output sof, output data);
	modport dev  (input valid, input sof, input data);
endinterface

// file: hw/lmp_pkg.sv
// Shared constants, parameter record and checksum helper
package lmp_pkg;

	// ----------------------------------------
	// Frame header and command codes
	// ----------------------------------------
	localparam logic [7:0] LMP_DIAG_ID    = 8'h3C;
	localparam logic [7:0] LMP_APP_CMD    = 8'h80;
	localparam logic [7:0] LMP_FILL       = 8'hFF;
	localparam logic [6:0] LMP_CODE_DUAL  = 7'h08;
	localparam logic [6:0] LMP_CODE_MOTOR = 7'h09;
	localparam logic [6:0] LMP_CODE_FUSE  = 7'h10;
	localparam logic [6:0] LMP_CODE_STALL = 7'h16;
	localparam logic [4:0] LMP_FUSE_HEAD  = 5'h1F;
	localparam logic [7:0] LMP_MOTOR_FIX  = 8'hA2;

	// ----------------------------------------
	// Frame shape: id, data bytes, checksum
	// ----------------------------------------
	localparam int         LMP_NBYTES   = 8;
	localparam logic [3:0] LMP_CSUM_POS = 4'h9;

	// ----------------------------------------
	// Host register map (AHB-Lite byte offsets)
	// ----------------------------------------
	localparam logic [7:0] LMP_OFS_CMD    = 8'h00;
	localparam logic [7:0] LMP_OFS_DLO    = 8'h04;
	localparam logic [7:0] LMP_OFS_DHI    = 8'h08;
	localparam logic [7:0] LMP_OFS_CURPOS = 8'h0C;
	localparam logic [7:0] LMP_OFS_STATUS = 8'h10;
	localparam int         LMP_GO_BIT     = 31;
	localparam int         LMP_ST_BUSY    = 0;
	localparam int         LMP_ST_REFUSED = 1;

	// ----------------------------------------
	// Motor and stall parameter record
	// ----------------------------------------
	typedef struct packed {
		logic [3:0]  run_current;
		logic [3:0]  hold_current;
		logic [3:0]  vmax;
		logic [3:0]  vmin;
		logic [2:0]  min_sample_count;
		logic        shaft_dir;
		logic [3:0]  accel_index;
		logic [3:0]  absolute_stall_threshold;
		logic [3:0]  relative_stall_threshold;
		logic [2:0]  min_zero_crossings;
		logic        ramp_profile_select;
		logic [1:0]  step_mode;
		logic        full_duty_stall_enable;
		logic        pwm_jitter_enable;
		logic        pwm_rate_select;
		logic [10:0] secure_position;
	} lmp_param_s;

	localparam lmp_param_s LMP_PARAM_RST = '0;

	// Classic checksum: add with end-around carry
	function automatic logic [7:0] lmp_csum_add(input logic [7:0] sum,
		input logic [7:0] b);
		logic [8:0] t;
		t = {1'b0, sum} + {1'b0, b};
		return t[7:0] + {7'h00, t[8]};
	endfunction

endpackage

// file: test/lmp_link_checker.sv
// Link framing and node action checks
`timescale 1ns/1ps
module lmp_link_checker
	import lmp_pkg::*;
(
	input logic       mclk_in,
	input logic       arst_n_in,
	input logic       valid,
	input logic       sof,
	input logic [7:0] data,
	input logic       motion_done_in,
	input logic       move_start_out,
	input logic       move_busy_out,
	input logic       param_load_out,
	input logic       fuse_prog_out,
	input logic [7:0] frames_taken_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!arst_n_in);
	logic act;
	assign act = move_start_out | param_load_out | fuse_prog_out;

	AST_SOF_ID: assert property (sof |-> valid && data == LMP_DIAG_ID)
		else $error("frame start without id");
	AST_APP_BYTE: assert property (valid && sof |=>
		valid && data == LMP_APP_CMD)
		else $error("bad application byte");
	AST_CODE_MARK: assert property (valid && sof ##1 valid |=>
		data[7])
		else $error("code byte bit7 clear");
	AST_FRAME_LEN: assert property (valid && sof |=>
		(valid && !sof) [*8] ##1 (valid && !sof) ##1 !valid)
		else $error("frame length wrong");
	AST_ACT_CSUM: assert property (act |->
		$past(valid, 2) && !$past(valid))
		else $error("action not after checksum");
	AST_ONE_ACT: assert property ($onehot0({move_start_out,
		param_load_out, fuse_prog_out}))
		else $error("two actions at once");
	AST_TAKEN_STEP: assert property ($changed(frames_taken_out) |->
		act && frames_taken_out == $past(frames_taken_out) + 8'h01)
		else $error("taken count step wrong");
	AST_START_IDLE: assert property (move_start_out |->
		!$past(move_busy_out))
		else $error("move started while busy");
	AST_BUSY_CLEAR: assert property ($fell(move_busy_out) |->
		$past(motion_done_in) || $past(motion_done_in, 2))
		else $error("busy cleared without done");
	cover property (move_start_out);
	cover property (param_load_out && move_busy_out);
	cover property (fuse_prog_out);
endmodule

// file: test/tb_top.sv
// Host and node ends joined, driven over AHB-Lite
`timescale 1ns/1ps
module tb_top;
	import lmp_pkg::*;
	logic mclk_in = 0, arst_n_in = 0, hsel = 0, hwrite = 0, done = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata;
	logic [1:0] htrans = 0;
	logic hready, hresp, start, busy, load, fprog;
	logic [3:0] vmax, vmin;
	logic [15:0] tgt, rel;
	logic [2:0] fidx;
	logic [7:0] fdat, taken, dropped, taken_b, dropped_b;
	lmp_param_s p;
	logic [7:0] wb [0:9];
	int n_errors = 0, comparisons = 0, nb = 0, n_st = 0, n_ld = 0, n_fu = 0;
	always #2.5 mclk_in = ~mclk_in;
	lmp_link_if link ();
	lmp_link_if link_b ();
	lmp_host lmp_host_inst (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
		.link(link), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
		.hready_in(hready), .hreadyout_out(hready), .hrdata_out(hrdata),
		.hresp_out(hresp));
	lmp_dev lmp_dev_inst (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
		.link(link), .phys_addr_in(7'h15), .motion_done_in(done),
		.move_start_out(start), .move_busy_out(busy), .move_vmax_out(vmax),
		.move_vmin_out(vmin), .first_target_position_out(tgt),
		.second_relative_move_out(rel), .param_out(p),
		.param_load_out(load), .fuse_prog_out(fprog),
		.fuse_byte_index_out(fidx), .fuse_data_out(fdat),
		.frames_taken_out(taken), .frames_dropped_out(dropped));
	// Second node fed by raw bytes: a bad checksum, a cut frame, a good frame and a wrong-id frame
	lmp_dev lmp_dev_inst2 (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
		.link(link_b), .phys_addr_in(7'h15), .motion_done_in(1'b0),
		.move_start_out(), .move_busy_out(), .move_vmax_out(),
		.move_vmin_out(), .first_target_position_out(),
		.second_relative_move_out(), .param_out(), .param_load_out(),
		.fuse_prog_out(), .fuse_byte_index_out(), .fuse_data_out(),
		.frames_taken_out(taken_b), .frames_dropped_out(dropped_b));
	lmp_link_checker lmp_link_checker_inst (.mclk_in(mclk_in),
		.arst_n_in(arst_n_in), .valid(link.valid), .sof(link.sof),
		.data(link.data), .motion_done_in(done), .move_start_out(start),
		.move_busy_out(busy), .param_load_out(load),
		.fuse_prog_out(fprog), .frames_taken_out(taken));
	initial begin
		link_b.valid = 0;
		link_b.sof = 0;
		link_b.data = 0;
	end
	// Pulses and wire bytes captured as they pass
	always @(posedge mclk_in) begin
		n_st += (start === 1'b1);
		n_ld += (load === 1'b1);
		n_fu += (fprog === 1'b1);
		if (link.valid === 1'b1) begin
			if (link.sof) nb = 0;
			if (nb < 10) wb[nb] = link.data;
			nb++;
		end
	end
	task automatic report_and_stop();
		if (n_errors == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wait_rdy();
		int i = 0;
		do begin
			@(posedge mclk_in);
			i++;
		end while (hready !== 1'b1 && i < 20);
		if (i >= 20) begin
			n_errors++;
			report_and_stop();
		end
	endtask
	task automatic ahb(input logic wr, input logic [7:0] ofs,
		input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1;
		htrans <= 2'h2;
		haddr <= {24'h0, ofs};
		hwrite <= wr;
		wait_rdy();
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask
	// Sends one frame, then checks taken and dropped steps
	task automatic frame(input logic [6:0] code, input logic [7:0] b3,
		input logic [31:0] dlo, input logic [7:0] dhi, input int dt, dd);
		logic [31:0] rd;
		logic [7:0] t0, d0;
		int i = 0;
		t0 = taken;
		d0 = dropped;
		ahb(1, LMP_OFS_DLO, dlo, rd);
		ahb(1, LMP_OFS_DHI, {24'h0, dhi}, rd);
		ahb(1, LMP_OFS_CMD, {1'b1, 15'h0, b3, 1'b0, code}, rd);
		while (i < 40 && taken === t0 && dropped === d0) begin
			@(posedge mclk_in);
			i++;
		end
		repeat (2) @(posedge mclk_in);
		check(taken - t0, dt);
		check(dropped - d0, dd);
	endtask
	task automatic dual(input logic [7:0] b3, v, input logic [15:0] p1, p2,
		input int dt, dd);
		frame(LMP_CODE_DUAL, b3, {v, p1, p2[15:8]}, p2[7:0], dt, dd);
	endtask
	task automatic done_pulse();
		done <= 1;
		@(posedge mclk_in);
		done <= 0;
		repeat (2) @(posedge mclk_in);
	endtask
	function automatic logic [7:0] csum(input logic [7:0] b [0:9]);
		logic [8:0] t;
		logic [7:0] s = 0;
		for (int k = 1; k < 9; k++) begin
			t = s + b[k];
			s = t[7:0] + t[8];
		end
		return ~s;
	endfunction
	task automatic raw(input logic [7:0] b [0:9], input int n);
		for (int k = 0; k < n; k++) begin
			link_b.valid <= 1;
			link_b.sof <= (k == 0);
			link_b.data <= b[k];
			@(posedge mclk_in);
		end
		link_b.valid <= 0;
		link_b.sof <= 0;
		link_b.data <= ~b[n-1];
		repeat (4) @(posedge mclk_in);
	endtask
	task automatic t_dual();
		int s0 = n_st;
		dual(8'h95, 8'hA3, 16'h1234, 16'h0040, 1, 0);
		check(vmax, 4'hA);
		check(vmin, 4'h3);
		check({tgt, rel}, 32'h1234_0040);
		check(busy, 1'b1);
		dual(8'h00, 8'h11, 16'h0777, 16'h0100, 0, 1);
		check(tgt, 16'h1234);
		done_pulse();
		check(busy, 1'b0);
		dual(8'h05, 8'h62, 16'h0777, 16'h0100, 1, 0);
		check(n_st - s0, 2);
	endtask
	task automatic t_param();
		frame(LMP_CODE_STALL, 8'h95, 32'h5AC3_B79E, 8'hD6, 1, 0);
		check({p.run_current, p.hold_current, p.vmax, p.vmin}, 16'h5AC3);
		check({p.min_sample_count, p.shaft_dir, p.accel_index,
			p.absolute_stall_threshold, p.relative_stall_threshold},
			16'hB79E);
		check({p.min_zero_crossings, p.ramp_profile_select, p.step_mode,
			p.full_duty_stall_enable, p.pwm_jitter_enable}, 8'hD6);
		frame(LMP_CODE_MOTOR, 8'h00, 32'h2187_6C4D, 8'hFB, 1, 0);
		check(busy, 1'b1);
		check({p.run_current, p.hold_current, p.vmax, p.vmin}, 16'h2187);
		check({p.secure_position, p.shaft_dir, p.accel_index},
			16'h69AC);
		check({p.pwm_rate_select, p.ramp_profile_select, p.step_mode,
			p.pwm_jitter_enable}, 5'h1D);
		check(p.absolute_stall_threshold, 4'h9);
		frame(LMP_CODE_MOTOR, 8'h00, 32'h2187_6C4D, 8'h59, 0, 1);
		done_pulse();
	endtask
	task automatic t_refuse();
		logic [31:0] rd;
		int l0 = n_ld;
		ahb(1, LMP_OFS_CURPOS, 32'h5555, rd);
		ahb(0, LMP_OFS_CURPOS, 0, rd);
		check(rd, 32'h0000_5555);
		dual(8'h00, 8'h11, 16'h5555, 16'h0100, 0, 0);
		ahb(0, LMP_OFS_STATUS, 0, rd);
		check(rd[LMP_ST_REFUSED], 1'b1);
		check(rd[LMP_ST_BUSY], 1'b0);
		dual(8'h00, 8'h11, 16'h0200, 16'h0200, 0, 0);
		frame(7'h11, 8'h00, 32'h0, 8'h0, 0, 1);
		frame(LMP_CODE_STALL, 8'h96, 32'h0, 8'h0, 0, 1);
		frame(LMP_CODE_STALL, 8'h00, 32'h0, 8'hFF, 1, 0);
		ahb(1, 8'h14, 32'hFFFF_FFFF, rd);
		ahb(0, 8'h14, 0, rd);
		check(rd, 0);
		check(hresp, 1'b0);
		check(n_ld - l0, 1);
	endtask
	task automatic t_fuse();
		logic [7:0] e [0:9] = '{8'h3C, 8'h80, 8'h90, 8'h00, 8'hFD,
			8'h3C, 8'hFF, 8'hFF, 8'hFF, 8'h00};
		int f0 = n_fu;
		e[9] = csum(e);
		frame(LMP_CODE_FUSE, 8'h00, 32'hFD3C_FFFF, 8'hFF, 1, 0);
		check({fidx, fdat}, 11'h53C);
		for (int k = 0; k < 10; k++) check(wb[k], e[k]);
		frame(LMP_CODE_FUSE, 8'h00, 32'hFD3C_00FF, 8'hFF, 0, 1);
		check(n_fu - f0, 1);
		e[9] = e[9] ^ 8'h01;
		raw(e, 10);
		check({taken_b, dropped_b}, 0);
		e[9] = csum(e);
		raw(e, 6);
		raw(e, 10);
		check({taken_b, dropped_b}, 16'h0100);
		e[0] = 8'h3D;
		raw(e, 10);
		check({taken_b, dropped_b}, 16'h0101);
	endtask
	initial begin
		repeat (16) @(posedge mclk_in);
		arst_n_in <= 1;
		@(posedge mclk_in);
		t_dual();
		t_param();
		t_refuse();
		t_fuse();
		report_and_stop();
	end
endmodule
